// ===== hw/pta_arbiter.sv
// Two-level PCI bus arbiter with its control registers
// Operation
// [R1] Banks 1 to 3 each have a fixed-priority select and a rotate control.
// [R2] Select 0: ISA over master0, master1 over master2, CPU over master3; 1 reverses.
// [R3] Rotate clear: the same line of the bank always leads.
// [R4] Rotate set: bank order flips after each grant to the leading line.
// [R5] Bank 0 select and rotate are tied to 0, not writable.
// [R6] Two-bit level-two fixed mode picks one of four rotated orders.
// [R7] Level-two rotate enable chooses fixed or round-robin schemes; resets enabled.
// [R8] Round-robin has 8 slots: four fixed schemes, four programmable ones.
// [R9] Bank 3 to 1 rotate enables sit in bits 7:5, reset to 111.
// [R10] Bank fixed selects in bits 2:0; IDE always beats external master 4.
// [R11] Three-bit super agent field: 000 off, then IDE, ISA, CPU, masters 0-3.
// [R12] Four two-bit programmable slot selectors, all reset to zero.
// [R13] The four bank winners, bank 0 holding IDE, meet at level two; exactly one grant at a time.
`timescale 1ns/1ps
module pta_arbiter
  import pta_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ide_bus_request_n,
  input wire logic ext_master4_request_n,
  input wire logic isa_bridge_bus_request_n,
  input wire logic ext_master0_request_n,
  input wire logic ext_master1_request_n,
  input wire logic ext_master2_request_n,
  input wire logic host_cpu_request_n,
  input wire logic ext_master3_request_n,
  output logic ide_grant_n,
  output logic ext_master4_grant_n,
  output logic isa_bridge_grant_n,
  output logic ext_master0_grant_n,
  output logic ext_master1_grant_n,
  output logic ext_master2_grant_n,
  output logic host_cpu_grant_n,
  output logic ext_master3_grant_n
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------

  // First valid candidate walking from the scheme's start bank
  function automatic logic [1:0] pick_bank(input logic [3:0] valid, input logic [1:0] scheme);
    logic [1:0] idx;
    logic found;
    idx = scheme;
    found = 1'b0;
    pick_bank = scheme;
    for (int i = 0; i < 4; i++)
    begin
      idx = 2'(scheme + 2'(i));
      if (!found && valid[idx])
      begin
        pick_bank = idx;
        found = 1'b1;
      end
    end
  endfunction : pick_bank

  function automatic logic [2:0] super_index(input logic [2:0] code);
    logic [2:0] r;
    r = RQ_IDE;
    unique case (code)
      3'h1: r = RQ_IDE;
      3'h2: r = RQ_ISA;
      3'h3: r = RQ_CPU;
      3'h4: r = RQ_M0;
      3'h5: r = RQ_M1;
      3'h6: r = RQ_M2;
      3'h7: r = RQ_M3;
      default: r = RQ_IDE;
    endcase
    super_index = r;
  endfunction : super_index

  // One-hot grant vector, shared by reset parking and arbitration
  function automatic logic [7:0] grant_onehot(input logic [2:0] who);
    logic [7:0] v;
    v = 8'h00;
    v[who] = 1'b1;
    grant_onehot = v;
  endfunction : grant_onehot

  // ----------------------------------------
  // State and bus front end
  // ----------------------------------------
  pta_arb_state_t st;
  pta_arb_state_t next_st;
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [7:0] wr_data;
  logic [ADDR_W-1:0] rd_addr;
  logic [7:0] rd_data;

  pta_axil u_axil (
    .mclk(mclk),
    .reset(reset),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  // ----------------------------------------
  // Requests, active high inside
  // ----------------------------------------
  logic [7:0] req;
  assign req = ~{ext_master3_request_n, host_cpu_request_n, ext_master2_request_n,
                 ext_master1_request_n, ext_master0_request_n, isa_bridge_bus_request_n,
                 ext_master4_request_n, ide_bus_request_n};

  // ----------------------------------------
  // Level one
  // ----------------------------------------
  logic [3:0] bank_fixed;
  logic [3:0] bank_rotate;
  logic [3:0] take_up;
  logic [3:0] take_lo;
  logic [3:0] win_up;
  logic [3:0] win_lo;
  logic [3:0] bank_valid;

  assign bank_fixed = {st.prio_ctrl_one[FLD_FIXED_LSB +: 3], 1'b0}; // [R1] [R2] [R5] [R10]
  assign bank_rotate = {st.prio_ctrl_one[FLD_ROTATE_LSB +: 3], 1'b0}; // [R1] [R5] [R9]
  assign bank_valid = win_up | win_lo;

  // Bank 0 reuses the bank cell with constant controls, so IDE leads master 4
  pta_bank u_bank0 (
    .mclk(mclk),
    .reset(reset),
    .req_upper(req[0]),
    .req_lower(req[1]),
    .fixed_sel(bank_fixed[0]),
    .rotate_en(bank_rotate[0]),
    .take_upper(take_up[0]),
    .take_lower(take_lo[0]),
    .win_upper(win_up[0]),
    .win_lower(win_lo[0])
  );

  pta_bank u_bank1 (
    .mclk(mclk),
    .reset(reset),
    .req_upper(req[2]),
    .req_lower(req[3]),
    .fixed_sel(bank_fixed[1]),
    .rotate_en(bank_rotate[1]),
    .take_upper(take_up[1]),
    .take_lower(take_lo[1]),
    .win_upper(win_up[1]),
    .win_lower(win_lo[1])
  );

  pta_bank u_bank2 (
    .mclk(mclk),
    .reset(reset),
    .req_upper(req[4]),
    .req_lower(req[5]),
    .fixed_sel(bank_fixed[2]),
    .rotate_en(bank_rotate[2]),
    .take_upper(take_up[2]),
    .take_lower(take_lo[2]),
    .win_upper(win_up[2]),
    .win_lower(win_lo[2])
  );

  pta_bank u_bank3 (
    .mclk(mclk),
    .reset(reset),
    .req_upper(req[6]),
    .req_lower(req[7]),
    .fixed_sel(bank_fixed[3]),
    .rotate_en(bank_rotate[3]),
    .take_upper(take_up[3]),
    .take_lower(take_lo[3]),
    .win_upper(win_up[3]),
    .win_lower(win_lo[3])
  );

  // ----------------------------------------
  // Level two
  // ----------------------------------------
  logic l2_rotate;
  logic [1:0] scheme;
  logic [1:0] l2_bank;
  logic [2:0] l2_winner;
  logic [2:0] bank0_winner;
  logic [2:0] bank1_winner;
  logic [2:0] bank2_winner;
  logic [2:0] bank3_winner;
  logic [2:0] sa_index;
  logic sa_active;
  logic [2:0] winner;
  logic rearb;

  assign l2_rotate = st.prio_ext_ctrl[FLD_L2_ROTATE];
  assign sa_index = super_index(st.prio_ext_ctrl[FLD_SUPER_LSB +: 3]);
  assign sa_active = (st.prio_ext_ctrl[FLD_SUPER_LSB +: 3] != 3'h0) && req[sa_index]; // [R11]

  always_comb
  begin
    scheme = st.prio_ctrl_one[FLD_FPMOD_LSB +: 2]; // [R6]
    if (l2_rotate) // [R7]
    begin
      // Slots 0-3 run the four fixed schemes, slots 4-7 the programmable ones
      if (st.slot <= SLOT_FIXED_LAST) // [R8]
      begin
        scheme = st.slot[1:0];
      end
      else
      begin
        scheme = st.slot_select[2*st.slot[1:0] +: 2]; // [R12]
      end
    end
  end

  assign l2_bank = pick_bank(bank_valid, scheme); // [R13]

  // Each bank's winner as a requester index; level two only picks the bank
  assign bank0_winner = {2'h0, win_lo[0]};
  assign bank1_winner = {2'h1, win_lo[1]};
  assign bank2_winner = {2'h2, win_lo[2]};
  assign bank3_winner = {2'h3, win_lo[3]};

  always_comb
  begin
    unique case (l2_bank)
      2'h0: l2_winner = bank0_winner;
      2'h1: l2_winner = bank1_winner;
      2'h2: l2_winner = bank2_winner;
      2'h3: l2_winner = bank3_winner;
    endcase
  end
  assign winner = sa_active ? sa_index : l2_winner;

  // Bus is handed over only once the owner drops its request; no preemption
  assign rearb = !req[st.owner] && (req != 8'h00);

  always_comb
  begin
    for (int k = 0; k < 4; k++)
    begin
      take_up[k] = rearb && (winner == 3'(2*k));
      take_lo[k] = rearb && (winner == 3'(2*k+1));
    end
  end

  // ----------------------------------------
  // Register and grant update
  // ----------------------------------------
  always_comb
  begin
    next_st = st;
    if (wr_en)
    begin
      unique case (wr_addr)
        OFS_PRIO_CTRL_ONE: next_st.prio_ctrl_one = wr_data;
        // Reserved upper bits are dropped so they read back as zero
        OFS_PRIO_EXT_CTRL: next_st.prio_ext_ctrl = wr_data & MASK_PRIO_EXT_CTRL;
        OFS_SLOT_SELECT: next_st.slot_select = wr_data;
        default: next_st.slot_select = st.slot_select;
      endcase
    end
    if (rearb)
    begin
      // One-hot grant: a new owner replaces the old in the same edge
      next_st.owner = winner;
      next_st.grant = grant_onehot(winner); // [R13]
      // Super agent grants step the slot too, so the rotation never stalls
      if (l2_rotate)
      begin
        next_st.slot = 3'(st.slot + 3'h1); // [R8]
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      st.prio_ctrl_one <= RST_PRIO_CTRL_ONE; // [R9]
      st.prio_ext_ctrl <= RST_PRIO_EXT_CTRL; // [R7] [R11]
      st.slot_select <= RST_SLOT_SELECT; // [R12]
      // Park on the CPU so exactly one grant stands before any request
      st.grant <= grant_onehot(RQ_PARK);
      st.owner <= RQ_PARK;
      st.slot <= 3'h0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Read mux and pins
  // ----------------------------------------
  always_comb
  begin
    unique case (rd_addr)
      OFS_PRIO_CTRL_ONE: rd_data = st.prio_ctrl_one;
      OFS_PRIO_EXT_CTRL: rd_data = st.prio_ext_ctrl;
      OFS_SLOT_SELECT: rd_data = st.slot_select;
      // Status is read-only; a write to it falls to the default arm
      OFS_GRANT_STATUS: rd_data = {2'h0, st.slot, st.owner};
      default: rd_data = 8'h00;
    endcase
  end

  assign ide_grant_n = ~st.grant[RQ_IDE];
  assign ext_master4_grant_n = ~st.grant[RQ_EXT4];
  assign isa_bridge_grant_n = ~st.grant[RQ_ISA];
  assign ext_master0_grant_n = ~st.grant[RQ_M0];
  assign ext_master1_grant_n = ~st.grant[RQ_M1];
  assign ext_master2_grant_n = ~st.grant[RQ_M2];
  assign host_cpu_grant_n = ~st.grant[RQ_CPU];
  assign ext_master3_grant_n = ~st.grant[RQ_M3];

endmodule : pta_arbiter

// ===== hw/pta_pkg.sv
// Package of register map, field positions, reset values and state types for the arbiter
package pta_pkg;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_PRIO_CTRL_ONE = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PRIO_EXT_CTRL = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_SLOT_SELECT = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_GRANT_STATUS = 8'h0C;

  localparam logic [7:0] RST_PRIO_CTRL_ONE = 8'hE0;
  localparam logic [7:0] RST_PRIO_EXT_CTRL = 8'h01;
  localparam logic [7:0] RST_SLOT_SELECT = 8'h00;
  localparam logic [7:0] MASK_PRIO_EXT_CTRL = 8'h0F;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int FLD_ROTATE_LSB = 5;
  localparam int FLD_FPMOD_LSB = 3;
  localparam int FLD_FIXED_LSB = 0;
  localparam int FLD_SUPER_LSB = 1;
  localparam int FLD_L2_ROTATE = 0;

  // ----------------------------------------
  // Requester numbering: bank * 2 + lower member
  // ----------------------------------------
  localparam logic [2:0] RQ_IDE = 3'h0;
  localparam logic [2:0] RQ_EXT4 = 3'h1;
  localparam logic [2:0] RQ_ISA = 3'h2;
  localparam logic [2:0] RQ_M0 = 3'h3;
  localparam logic [2:0] RQ_M1 = 3'h4;
  localparam logic [2:0] RQ_M2 = 3'h5;
  localparam logic [2:0] RQ_CPU = 3'h6;
  localparam logic [2:0] RQ_M3 = 3'h7;
  localparam logic [2:0] RQ_PARK = RQ_CPU;
  localparam logic [2:0] SLOT_FIXED_LAST = 3'h3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic flip;
  } pta_bank_state_t;

  typedef struct packed {
    logic aw_held;
    logic [ADDR_W-1:0] awaddr;
    logic w_held;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } pta_axil_state_t;

  typedef struct packed {
    logic [7:0] prio_ctrl_one;
    logic [7:0] prio_ext_ctrl;
    logic [7:0] slot_select;
    logic [7:0] grant;
    logic [2:0] owner;
    logic [2:0] slot;
  } pta_arb_state_t;

  function automatic logic pta_reg_hit(input logic [ADDR_W-1:0] a);
    pta_reg_hit = (a == OFS_PRIO_CTRL_ONE) || (a == OFS_PRIO_EXT_CTRL) ||
                  (a == OFS_SLOT_SELECT) || (a == OFS_GRANT_STATUS);
  endfunction : pta_reg_hit

endpackage : pta_pkg

// ===== hw/pta_bank.sv
// Two-member level-one bank with fixed-priority select and rotate control
`timescale 1ns/1ps
module pta_bank
  import pta_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic req_upper,
  input wire logic req_lower,
  input wire logic fixed_sel,
  input wire logic rotate_en,
  input wire logic take_upper,
  input wire logic take_lower,
  output logic win_upper,
  output logic win_lower
);

  pta_bank_state_t st;
  pta_bank_state_t next_st;
  logic upper_first;

  // Upper member leads when the effective order bit is 0
  assign upper_first = ~(fixed_sel ^ st.flip);
  assign win_upper = req_upper & (upper_first | ~req_lower);
  assign win_lower = req_lower & ~win_upper;

  always_comb
  begin
    next_st = st;
    // Only a grant to the leading line turns the order over
    if (rotate_en && ((take_upper && upper_first) || (take_lower && !upper_first))) // [R4]
    begin
      next_st.flip = ~st.flip;
    end
    if (!rotate_en)
    begin
      next_st.flip = 1'b0; // [R3]
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

endmodule : pta_bank

// ===== hw/pta_axil.sv
// AXI4-Lite slave front end with byte-lane-0 register strobes
`timescale 1ns/1ps
module pta_axil
  import pta_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wr_en,
  output logic [ADDR_W-1:0] wr_addr,
  output logic [7:0] wr_data,
  output logic [ADDR_W-1:0] rd_addr,
  input wire logic [7:0] rd_data
);

  pta_axil_state_t st;
  pta_axil_state_t next_st;

  // Holding the channels while a response waits keeps one write in flight
  assign s_axi_awready = ~st.aw_held & ~st.bvalid;
  assign s_axi_wready = ~st.w_held & ~st.bvalid;
  assign s_axi_arready = ~st.rvalid;
  assign wr_en = st.aw_held & st.w_held & st.wstrb0 & pta_reg_hit(st.awaddr);
  assign wr_addr = st.awaddr;
  assign wr_data = st.wdata;
  assign rd_addr = s_axi_araddr;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rresp = st.rresp;
  assign s_axi_rdata = {24'h000000, st.rdata};

  always_comb
  begin
    next_st = st;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_st.aw_held = 1'b1;
      next_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_st.w_held = 1'b1;
      next_st.wdata = s_axi_wdata[7:0];
      next_st.wstrb0 = s_axi_wstrb[0];
    end
    if (st.aw_held && st.w_held)
    begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = pta_reg_hit(st.awaddr) ? RESP_OKAY : RESP_SLVERR;
    end
    if (st.bvalid && s_axi_bready)
    begin
      next_st.bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_st.rvalid = 1'b1;
      next_st.rdata = pta_reg_hit(s_axi_araddr) ? rd_data : 8'h00;
      next_st.rresp = pta_reg_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (st.rvalid && s_axi_rready)
    begin
      next_st.rvalid = 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

endmodule : pta_axil

// ===== bench/pta_arbiter_properties.sv
// Checker of grant and read-data behaviour at the arbiter's ports
`timescale 1ns/1ps
module pta_arbiter_checker (
  input wire logic mclk,
  input wire logic reset,
  input wire logic ide_bus_request_n,
  input wire logic ext_master4_request_n,
  input wire logic isa_bridge_bus_request_n,
  input wire logic ext_master0_request_n,
  input wire logic ext_master1_request_n,
  input wire logic ext_master2_request_n,
  input wire logic host_cpu_request_n,
  input wire logic ext_master3_request_n,
  input wire logic ide_grant_n,
  input wire logic ext_master4_grant_n,
  input wire logic isa_bridge_grant_n,
  input wire logic ext_master0_grant_n,
  input wire logic ext_master1_grant_n,
  input wire logic ext_master2_grant_n,
  input wire logic host_cpu_grant_n,
  input wire logic ext_master3_grant_n,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata
);
  logic [7:0] r;
  logic [7:0] g;
  assign r = ~{ext_master3_request_n, host_cpu_request_n, ext_master2_request_n,
    ext_master1_request_n, ext_master0_request_n, isa_bridge_bus_request_n,
    ext_master4_request_n, ide_bus_request_n};
  assign g = ~{ext_master3_grant_n, host_cpu_grant_n, ext_master2_grant_n, ext_master1_grant_n,
    ext_master0_grant_n, isa_bridge_grant_n, ext_master4_grant_n, ide_grant_n};
  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (reset);
  one_grant_a: assert property ($onehot(g)) else $error("grants not one-hot");
  reset_park_a: assert property ($past(reset) |-> g == 8'h40)
    else $error("no park on cpu after reset");
  owner_holds_a: assert property (|(g & r) |=> g == $past(g))
    else $error("owner preempted");
  handover_a: assert property (!(|(g & r)) && (|r) |=> g != $past(g))
    else $error("released bus not handed over");
  grant_requested_a: assert property ($changed(g) |-> |(g & $past(r)))
    else $error("grant to idle requester");
  park_idle_a: assert property (r == 8'h00 |=> $stable(g)) else $error("park lost");
  ide_over_m4_a: assert property ($rose(g[1]) |-> !$past(r[0]))
    else $error("master4 beat ide");
  rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
endmodule : pta_arbiter_checker

bind pta_arbiter pta_arbiter_checker chk (.*);

// ===== bench/pta_masters.sv
// Behavioural model of the requesting bus masters
`timescale 1ns/1ps
module pta_masters (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [7:0] want,
  output logic [7:0] req_n
);
  // Requests are active low levels that move only just after an edge
  always_ff @(posedge mclk)
  begin
    if (reset)
      req_n <= 8'hFF;
    else
      req_n <= ~want;
  end
endmodule : pta_masters

// ===== bench/test_pci_two_level_priority_arbiter.sv
// Self-checking bench for the two-level arbiter and its registers
`timescale 1ns/1ps
module test_pci_two_level_priority_arbiter;
  import pta_pkg::*;
  localparam logic [2:0] SA_IDX [8] = '{3'h0, 3'h0, 3'h2, 3'h6, 3'h3, 3'h4, 3'h5, 3'h7};
  logic mclk, reset, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb, flip;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [7:0] want, req_n, c1, c2, c3;
  wire [7:0] gnt_n;
  logic [2:0] owner, slot;
  int err_count, n_tests;
  pta_masters model (.mclk(mclk), .reset(reset), .want(want), .req_n(req_n));
  pta_arbiter uut (
    .ide_bus_request_n(req_n[0]), .ext_master4_request_n(req_n[1]),
    .isa_bridge_bus_request_n(req_n[2]), .ext_master0_request_n(req_n[3]),
    .ext_master1_request_n(req_n[4]), .ext_master2_request_n(req_n[5]),
    .host_cpu_request_n(req_n[6]), .ext_master3_request_n(req_n[7]),
    .ide_grant_n(gnt_n[0]), .ext_master4_grant_n(gnt_n[1]), .isa_bridge_grant_n(gnt_n[2]),
    .ext_master0_grant_n(gnt_n[3]), .ext_master1_grant_n(gnt_n[4]),
    .ext_master2_grant_n(gnt_n[5]), .host_cpu_grant_n(gnt_n[6]),
    .ext_master3_grant_n(gnt_n[7]), .*);
  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic compare(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : compare
  task automatic axi_write(input logic [7:0] a, input logic [7:0] d);
    logic aw_p, w_p;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw_p = 1'b1;
    w_p = 1'b1;
    // Each channel is released only at the edge that took it; a hang is the watchdog's
    do
    begin
      @(posedge mclk);
      if (s_axi_awready) aw_p = 1'b0;
      if (s_axi_wready) w_p = 1'b0;
      s_axi_awvalid <= aw_p;
      s_axi_wvalid <= w_p;
    end
    while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_write
  task automatic axi_read(input logic [7:0] a);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_read
  // ----------------------------------------
  // Arbitration model
  // ----------------------------------------
  function automatic logic [2:0] bank_win(input logic [7:0] m, input int b);
    logic lead;
    lead = (b == 0) ? 1'b0 : c1[b-1] ^ flip[b];
    return m[2*b+lead] ? 3'(2*b+lead) : 3'(2*b+1-lead);
  endfunction : bank_win
  function automatic logic [2:0] expect_win(input logic [7:0] m);
    logic [1:0] sch;
    int b;
    if (c2[3:1] != 3'h0 && m[SA_IDX[c2[3:1]]]) return SA_IDX[c2[3:1]];
    sch = !c2[0] ? c1[4:3] : (slot < 3'h4 ? slot[1:0] : c3[2*slot[1:0] +: 2]);
    for (int k = 0; k < 4; k++)
    begin
      b = (int'(sch) + k) % 4;
      if (m[2*b] || m[2*b+1]) return bank_win(m, b);
    end
    return owner;
  endfunction : expect_win
  task automatic grant_step(input logic [7:0] m);
    logic [2:0] w;
    int b;
    @(posedge mclk);
    want <= m;
    repeat (4) @(posedge mclk);
    // A requesting owner is never preempted, so the model only moves on a release
    if (m != 8'h00 && !m[owner])
    begin
      w = expect_win(m);
      b = int'(w) / 2;
      if (b != 0 && c1[4+b] && w[0] == (c1[b-1] ^ flip[b])) flip[b] = ~flip[b];
      if (c2[0]) slot = slot + 3'h1;
      owner = w;
    end
    compare({24'h0, ~gnt_n}, 32'h1 << owner);
  endtask : grant_step
  task automatic do_reset();
    reset <= 1'b1;
    want <= 8'h00;
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    {c1, c2, c3} = {8'hE0, 8'h01, 8'h00};
    flip = 4'h0;
    owner = 3'h6;
    slot = 3'h0;
  endtask : do_reset
  task automatic print_verdict();
    $display("Checks: %0d, mismatches: %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial
  begin
    #200000;
    err_count++;
    print_verdict();
  end
  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {16'h0, 32'h0, 4'hF};
    reset = 1'b1;
    want = 8'h00;
    err_count = 0;
    n_tests = 0;
    void'($urandom(80));
    do_reset();
    axi_read(OFS_PRIO_CTRL_ONE);
    compare(rd, 32'hE0);
    axi_read(OFS_PRIO_EXT_CTRL);
    compare(rd, 32'h01);
    axi_read(OFS_SLOT_SELECT);
    compare(rd, 32'h00);
    axi_read(8'h10);
    compare({30'h0, resp}, 32'h2);
    axi_write(8'h10, 8'h55);
    compare({30'h0, resp}, 32'h2);
    axi_write(OFS_PRIO_EXT_CTRL, 8'hFF);
    axi_read(OFS_PRIO_EXT_CTRL);
    compare(rd, 32'h0F);
    // Block 0 keeps reset defaults; later blocks draw a whole configuration
    for (int blk = 0; blk < 8; blk++)
    begin
      do_reset();
      if (blk > 0)
      begin
        c1 = 8'($urandom);
        c2 = {4'h0, 4'($urandom)};
        c3 = 8'($urandom);
        axi_write(OFS_PRIO_CTRL_ONE, c1);
        axi_write(OFS_PRIO_EXT_CTRL, c2);
        axi_write(OFS_SLOT_SELECT, c3);
        axi_read(OFS_PRIO_CTRL_ONE);
        compare(rd, {24'h0, c1});
      end
      for (int it = 0; it < 30; it++)
        grant_step(it % 5 == 0 ? 8'hFF : (it % 5 == 1 ? 8'h03 : 8'($urandom)));
      axi_read(OFS_GRANT_STATUS);
      compare(rd & 32'h3F, {26'h0, slot, owner});
    end
    print_verdict();
  end
endmodule : test_pci_two_level_priority_arbiter
